// [design/rtc_irq_pkg.sv]
// Purpose: shared constants for the timer and alarm interrupt block
// Assumes: 8-bit registers on a 4-bit word address, 20 MHz clock
// Notes:   all figures used by more than one file live here
package rtc_irq_pkg;

   // register offsets
   localparam logic [3:0] MIN_ALARM_ADDR  = 4'h8;
   localparam logic [3:0] HOUR_ALARM_ADDR = 4'h9;
   localparam logic [3:0] WDAY_ALARM_ADDR = 4'ha;
   localparam logic [3:0] PRESET_LO_ADDR  = 4'hb;
   localparam logic [3:0] PRESET_HI_ADDR  = 4'hc;
   localparam logic [3:0] EXT_CFG_ADDR    = 4'hd;
   localparam logic [3:0] FLAGS_ADDR      = 4'he;
   localparam logic [3:0] IRQ_CTRL_ADDR   = 4'hf;

   // field positions
   localparam int COMPARE_DISABLE_BIT = 7;
   localparam int CD_ENABLE_BIT       = 4;
   localparam int WDAY_DATE_SEL_BIT   = 3;
   localparam int CD_FLAG_BIT         = 4;
   localparam int ALARM_FLAG_BIT      = 3;
   localparam int CD_IRQ_EN_BIT       = 4;
   localparam int ALARM_IRQ_EN_BIT    = 3;
   localparam int CD_STOP_BIT         = 2;
   localparam int CLOCK_STOP_BIT      = 1;

   // writable bits of the control register; the rest read as zero
   localparam logic [7:0] IRQ_CTRL_MASK = 8'h3e;

   // reset values
   localparam logic [7:0]  ALARM_RST    = 8'h00;
   localparam logic [15:0] PRESET_RST   = 16'h0000;
   localparam logic [7:0]  EXT_CFG_RST  = 8'h00;
   localparam logic [7:0]  IRQ_CTRL_RST = 8'h00;

   // countdown source select codes
   localparam logic [2:0] SRC_4096HZ = 3'h0;
   localparam logic [2:0] SRC_64HZ   = 3'h1;
   localparam logic [2:0] SRC_1HZ    = 3'h2;
   localparam logic [2:0] SRC_MINUTE = 3'h3;
   localparam logic [2:0] SRC_HOUR   = 3'h4;

   // timing
   localparam int CLK_PERIOD_NS     = 50;
   localparam int RELEASE_FAST_NS   = 122000;
   localparam int RELEASE_SLOW_NS   = 7813000;
   localparam int RELEASE_FAST_CYC  = RELEASE_FAST_NS / CLK_PERIOD_NS;
   localparam int RELEASE_SLOW_CYC  = RELEASE_SLOW_NS / CLK_PERIOD_NS;
   localparam int MATCH_LATENCY_NS  = 1460000;
   localparam int MATCH_LATENCY_CYC = MATCH_LATENCY_NS / CLK_PERIOD_NS;
   localparam int RELEASE_CNT_W     = 18;

   // one alarm field: disabled, or its value bits equal the time
   function automatic logic field_hit(input logic [7:0] alarm,
                                      input logic [6:0] now,
                                      input logic [6:0] mask);
      return alarm[COMPARE_DISABLE_BIT] | ((alarm[6:0] & mask) == (now & mask));
   endfunction : field_hit

endpackage : rtc_irq_pkg

// [design/rtc_countdown.sv]
// Purpose: 16-bit reloading countdown with event pulse
// Assumes: src_tick_i is a one-cycle pulse at the selected source rate
// Notes:   event_o is high one enabled cycle after the 1 to 0 step
`timescale 1ns/100ps
`default_nettype none
module rtc_countdown #(
   parameter int WIDTH = 16
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   input  wire logic             enable_i,
   input  wire logic             src_tick_i,
   input  wire logic [WIDTH-1:0] preset_i,
   output logic      [WIDTH-1:0] count_o,
   output logic                  event_o
);

   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] count_d;
   logic             enable_q;
   logic             event_q;
   logic             event_d;
   wire              start    = enable_i & ~enable_q;
   wire              at_one   = (count_q == WIDTH'(1));

   always_comb begin
      count_d = count_q;
      event_d = 1'b0;
      if (start) begin
         count_d = preset_i;
      end else if (enable_i && src_tick_i) begin
         if (at_one) begin
            count_d = preset_i;
            event_d = 1'b1;
         end else if (count_q == '0) begin
            count_d = preset_i;
         end else begin
            count_d = count_q - WIDTH'(1);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_q  <= '0;
         enable_q <= 1'b0;
         event_q  <= 1'b0;
      end else if (ce_i) begin
         count_q  <= count_d;
         enable_q <= enable_i;
         event_q  <= event_d;
      end
   end

   assign count_o = count_q;
   assign event_o = event_q;

   AST_START_FROM_PRESET: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && start |=> count_q == $past(preset_i))
      else $error("countdown did not start from preset");

   AST_RELOAD_ON_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !start && enable_i && src_tick_i && at_one |=> event_q && count_q == $past(preset_i))
      else $error("no event and reload at 1 to 0 step");

endmodule : rtc_countdown
`default_nettype wire

// [design/rtc_alarm_match.sv]
// Purpose: alarm comparator evaluated on each minute update
// Assumes: time inputs already hold the new values in the tick cycle
// Notes:   match_o is a registered pulse, one enabled cycle long
`timescale 1ns/100ps
`default_nettype none
module rtc_alarm_match (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   input  wire logic       run_i,
   input  wire logic       min_tick_i,
   input  wire logic [7:0] min_alarm_i,
   input  wire logic [7:0] hour_alarm_i,
   input  wire logic [7:0] wday_alarm_i,
   input  wire logic       date_sel_i,
   input  wire logic [6:0] minute_i,
   input  wire logic [5:0] hour_i,
   input  wire logic [5:0] date_i,
   input  wire logic [2:0] weekday_i,
   output logic            match_o
);

   logic match_q;

   wire  min_ok   = rtc_irq_pkg::field_hit(min_alarm_i, minute_i, 7'h7f);
   wire  hour_ok  = rtc_irq_pkg::field_hit(hour_alarm_i, {1'b0, hour_i}, 7'h3f);
   wire  date_ok  = rtc_irq_pkg::field_hit(wday_alarm_i, {1'b0, date_i}, 7'h3f);
   wire  [6:0] day_bit = 7'h01 << weekday_i;
   wire  wday_ok  = wday_alarm_i[rtc_irq_pkg::COMPARE_DISABLE_BIT]
                    | (|(wday_alarm_i[6:0] & day_bit));
   wire  third_ok = date_sel_i ? date_ok : wday_ok;
   wire  all_ok   = min_ok & hour_ok & third_ok;
   // only a counter advance can match, never a register write
   wire  hit      = run_i & min_tick_i & all_ok;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         match_q <= 1'b0;
      end else if (ce_i) begin
         match_q <= hit;
      end
   end

   assign match_o = match_q;

   AST_EVERY_MINUTE: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && run_i && min_tick_i && min_alarm_i[7] && hour_alarm_i[7] && wday_alarm_i[7]
      |=> match_q)
      else $error("all fields disabled but no minute alarm");

   AST_MATCH_NEEDS_TICK: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(match_q) |-> $past(min_tick_i) && $past(run_i))
      else $error("alarm match without a minute update");

endmodule : rtc_alarm_match
`default_nettype wire

// [design/rtc_irq_top.sv]
// Purpose: timer and alarm interrupt logic with register port
// Assumes: tick inputs are one-cycle pulses from the time counters
// Notes:   interrupt pin is open drain, enable high while pulled low
//
// Summary of operation
// - events every preset times source period
// - select field picks one of five sources
// - step one to zero raises event, reloads
// - enable rising edge starts from preset
// - alarm match sets flag, pulls interrupt low
// - alarm interrupt holds low until cancelled
// - clock stop suppresses alarm events
// - three alarm registers at 08h to 0Ah
// - disable bit removes a field from compare
// - all fields disabled gives minute alarm
// - alarm only on counter advance
// - select bit chooses weekday or date
// - weekday mode uses a seven-day mask
// - alarm flag cleared only by writing zero
// - alarm enable only gates the pin
// - timer flag set per event, zero clears
// - timer interrupt releases after fixed time
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module rtc_irq_top #(
   parameter int PRESET_W     = 16,
   parameter int RELEASE_SLOW = rtc_irq_pkg::RELEASE_SLOW_CYC
) (
   // clock, reset, enable
   input  wire logic       MCLK_I,
   input  wire logic       SYS_RST_I,
   input  wire logic       CLK_EN_I,
   // register port
   input  wire logic [3:0] ADDR_I,
   input  wire logic [7:0] WDATA_I,
   input  wire logic       WR_I,
   input  wire logic       RD_I,
   output logic      [7:0] RDATA_O,
   // source ticks from the time base
   input  wire logic       TICK_4096HZ_I,
   input  wire logic       TICK_64HZ_I,
   input  wire logic       TICK_1HZ_I,
   input  wire logic       TICK_MINUTE_I,
   input  wire logic       TICK_HOUR_I,
   // running time counters, bcd
   input  wire logic [6:0] MINUTE_I,
   input  wire logic [5:0] HOUR_I,
   input  wire logic [5:0] DATE_I,
   input  wire logic [2:0] WEEKDAY_I,
   // open-drain interrupt pin
   input  wire logic       IRQ_I,
   output logic            IRQ_O,
   output logic            IRQ_OE_O
);

   // register state
   logic [7:0]          min_alarm_q;
   logic [7:0]          hour_alarm_q;
   logic [7:0]          wday_alarm_q;
   logic [PRESET_W-1:0] preset_q;
   logic [7:0]          ext_cfg_q;
   logic [7:0]          irq_ctrl_q;
   logic                cd_flag_q;
   logic                cd_flag_d;
   logic                alarm_flag_q;
   logic                alarm_flag_d;
   logic [7:0]          rdata_q;
   logic                irq_oe_q;
   logic                irq_oe_d;
   logic                timer_irq_q;
   logic                timer_irq_d;
   logic [rtc_irq_pkg::RELEASE_CNT_W-1:0] release_q;
   logic [rtc_irq_pkg::RELEASE_CNT_W-1:0] release_d;

   // write decode
   wire wr_min   = WR_I && ADDR_I == rtc_irq_pkg::MIN_ALARM_ADDR;
   wire wr_hour  = WR_I && ADDR_I == rtc_irq_pkg::HOUR_ALARM_ADDR;
   wire wr_wday  = WR_I && ADDR_I == rtc_irq_pkg::WDAY_ALARM_ADDR;
   wire wr_plo   = WR_I && ADDR_I == rtc_irq_pkg::PRESET_LO_ADDR;
   wire wr_phi   = WR_I && ADDR_I == rtc_irq_pkg::PRESET_HI_ADDR;
   wire wr_ext   = WR_I && ADDR_I == rtc_irq_pkg::EXT_CFG_ADDR;
   wire wr_flags = WR_I && ADDR_I == rtc_irq_pkg::FLAGS_ADDR;
   wire wr_ctrl  = WR_I && ADDR_I == rtc_irq_pkg::IRQ_CTRL_ADDR;

   // control fields
   wire       countdown_enable       = ext_cfg_q[rtc_irq_pkg::CD_ENABLE_BIT];
   wire       weekday_or_date_select = ext_cfg_q[rtc_irq_pkg::WDAY_DATE_SEL_BIT];
   wire [2:0] source_select          = ext_cfg_q[2:0];
   wire       countdown_irq_enable   = irq_ctrl_q[rtc_irq_pkg::CD_IRQ_EN_BIT];
   wire       alarm_irq_enable       = irq_ctrl_q[rtc_irq_pkg::ALARM_IRQ_EN_BIT];
   wire       countdown_stop         = irq_ctrl_q[rtc_irq_pkg::CD_STOP_BIT];
   wire       clock_stop             = irq_ctrl_q[rtc_irq_pkg::CLOCK_STOP_BIT];

   // source selection; unused codes give no tick
   logic src_raw;
   always_comb begin
      unique case (source_select)
         rtc_irq_pkg::SRC_4096HZ: src_raw = TICK_4096HZ_I;
         rtc_irq_pkg::SRC_64HZ:   src_raw = TICK_64HZ_I;
         rtc_irq_pkg::SRC_1HZ:    src_raw = TICK_1HZ_I;
         rtc_irq_pkg::SRC_MINUTE: src_raw = TICK_MINUTE_I;
         rtc_irq_pkg::SRC_HOUR:   src_raw = TICK_HOUR_I;
         default:                 src_raw = 1'b0;
      endcase
   end

   // countdown freezes under either stop bit
   wire src_tick = src_raw & ~countdown_stop & ~clock_stop;
   wire fast_src = (source_select == rtc_irq_pkg::SRC_4096HZ);

   wire [PRESET_W-1:0] cd_count;
   wire                cd_event;
   wire                alarm_hit;

   rtc_countdown #(
      .WIDTH      (PRESET_W)
   ) u_countdown (
      .clk_i      (MCLK_I),
      .rst_i      (SYS_RST_I),
      .ce_i       (CLK_EN_I),
      .enable_i   (countdown_enable),
      .src_tick_i (src_tick),
      .preset_i   (preset_q),
      .count_o    (cd_count),
      .event_o    (cd_event)
   );

   rtc_alarm_match u_alarm (
      .clk_i        (MCLK_I),
      .rst_i        (SYS_RST_I),
      .ce_i         (CLK_EN_I),
      .run_i        (~clock_stop),
      .min_tick_i   (TICK_MINUTE_I),
      .min_alarm_i  (min_alarm_q),
      .hour_alarm_i (hour_alarm_q),
      .wday_alarm_i (wday_alarm_q),
      .date_sel_i   (weekday_or_date_select),
      .minute_i     (MINUTE_I),
      .hour_i       (HOUR_I),
      .date_i       (DATE_I),
      .weekday_i    (WEEKDAY_I),
      .match_o      (alarm_hit)
   );

   // flags: a set in the clearing cycle wins
   wire clr_cd_flag    = wr_flags & ~WDATA_I[rtc_irq_pkg::CD_FLAG_BIT];
   wire clr_alarm_flag = wr_flags & ~WDATA_I[rtc_irq_pkg::ALARM_FLAG_BIT];
   assign cd_flag_d    = cd_event | (cd_flag_q & ~clr_cd_flag);
   assign alarm_flag_d = alarm_hit | (alarm_flag_q & ~clr_alarm_flag);

   // next control bits, so the pin follows a write in the same edge
   wire [7:0] irq_ctrl_d = wr_ctrl ? (WDATA_I & rtc_irq_pkg::IRQ_CTRL_MASK) : irq_ctrl_q;
   wire       cd_ie_d    = irq_ctrl_d[rtc_irq_pkg::CD_IRQ_EN_BIT];
   wire       alarm_ie_d = irq_ctrl_d[rtc_irq_pkg::ALARM_IRQ_EN_BIT];

   // timer-driven low level with automatic release
   wire [rtc_irq_pkg::RELEASE_CNT_W-1:0] release_len = fast_src
      ? rtc_irq_pkg::RELEASE_CNT_W'(rtc_irq_pkg::RELEASE_FAST_CYC)
      : rtc_irq_pkg::RELEASE_CNT_W'(RELEASE_SLOW);
   wire release_done = (release_q == rtc_irq_pkg::RELEASE_CNT_W'(1));

   always_comb begin
      timer_irq_d = timer_irq_q;
      release_d   = release_q;
      if (cd_event && cd_ie_d) begin
         timer_irq_d = 1'b1;
         release_d   = release_len;
      end else if (!cd_ie_d) begin
         timer_irq_d = 1'b0;
         release_d   = '0;
      end else if (timer_irq_q) begin
         timer_irq_d = ~release_done;
         release_d   = release_q - rtc_irq_pkg::RELEASE_CNT_W'(1);
      end
   end

   // alarm enable only gates, the flag holds the pin down
   assign irq_oe_d = (alarm_flag_d & alarm_ie_d) | timer_irq_d;

   // register writes
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         min_alarm_q  <= rtc_irq_pkg::ALARM_RST;
         hour_alarm_q <= rtc_irq_pkg::ALARM_RST;
         wday_alarm_q <= rtc_irq_pkg::ALARM_RST;
         preset_q     <= PRESET_W'(rtc_irq_pkg::PRESET_RST);
         ext_cfg_q    <= rtc_irq_pkg::EXT_CFG_RST;
         irq_ctrl_q   <= rtc_irq_pkg::IRQ_CTRL_RST;
      end else if (CLK_EN_I) begin
         if (wr_min)  min_alarm_q  <= WDATA_I;
         if (wr_hour) hour_alarm_q <= WDATA_I;
         if (wr_wday) wday_alarm_q <= WDATA_I;
         if (wr_plo)  preset_q[7:0] <= WDATA_I;
         if (wr_phi)  preset_q[PRESET_W-1:8] <= WDATA_I[PRESET_W-9:0];
         if (wr_ext)  ext_cfg_q <= WDATA_I;
         irq_ctrl_q <= irq_ctrl_d;
      end
   end

   // flags and pin
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         cd_flag_q    <= 1'b0;
         alarm_flag_q <= 1'b0;
         timer_irq_q  <= 1'b0;
         release_q    <= '0;
         irq_oe_q     <= 1'b0;
      end else if (CLK_EN_I) begin
         cd_flag_q    <= cd_flag_d;
         alarm_flag_q <= alarm_flag_d;
         timer_irq_q  <= timer_irq_d;
         release_q    <= release_d;
         irq_oe_q     <= irq_oe_d;
      end
   end

   // read mux; counter shows preset while disabled, live count while enabled
   wire [PRESET_W-1:0] cd_view = countdown_enable ? cd_count : preset_q;
   logic [7:0] rd_mux;
   always_comb begin
      unique case (ADDR_I)
         rtc_irq_pkg::MIN_ALARM_ADDR:  rd_mux = min_alarm_q;
         rtc_irq_pkg::HOUR_ALARM_ADDR: rd_mux = hour_alarm_q;
         rtc_irq_pkg::WDAY_ALARM_ADDR: rd_mux = wday_alarm_q;
         rtc_irq_pkg::PRESET_LO_ADDR:  rd_mux = cd_view[7:0];
         rtc_irq_pkg::PRESET_HI_ADDR:  rd_mux = 8'(cd_view[PRESET_W-1:8]);
         rtc_irq_pkg::EXT_CFG_ADDR:    rd_mux = ext_cfg_q;
         rtc_irq_pkg::FLAGS_ADDR:      rd_mux = {3'h0, cd_flag_q, alarm_flag_q, 3'h0};
         rtc_irq_pkg::IRQ_CTRL_ADDR:   rd_mux = irq_ctrl_q;
         default:                      rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         rdata_q <= 8'h00;
      end else if (CLK_EN_I) begin
         rdata_q <= RD_I ? rd_mux : 8'h00;
      end
   end

   // pin only ever pulls low
   assign IRQ_O    = 1'b0;
   assign IRQ_OE_O = irq_oe_q;
   assign RDATA_O  = rdata_q;

   AST_ALARM_SETS_FLAG: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      CLK_EN_I && alarm_hit |=> alarm_flag_q)
      else $error("alarm match did not set the flag");

   AST_ALARM_HOLDS_PIN: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      alarm_flag_q && alarm_irq_enable |-> IRQ_OE_O)
      else $error("pin released while alarm pending");

   AST_ALARM_FLAG_STICKY: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      CLK_EN_I && alarm_flag_q && !clr_alarm_flag |=> alarm_flag_q)
      else $error("alarm flag dropped without a zero write");

   AST_NO_ALARM_IN_STOP: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      CLK_EN_I && clock_stop |=> !alarm_hit)
      else $error("alarm raised while clock stopped");

   AST_ALARM_PULLS_PIN: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      CLK_EN_I && alarm_hit && alarm_ie_d |=> IRQ_OE_O)
      else $error("alarm match did not pull the pin low");

   AST_PIN_GATING: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      IRQ_OE_O == ((alarm_flag_q && alarm_irq_enable) || timer_irq_q))
      else $error("pin state disagrees with pending sources");

   AST_ALARM_CLEAR: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      CLK_EN_I && clr_alarm_flag && !alarm_hit |=> !alarm_flag_q)
      else $error("zero write did not clear the alarm flag");

   AST_TIMER_FLAG_STICKY: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      CLK_EN_I && cd_flag_q && !clr_cd_flag |=> cd_flag_q)
      else $error("timer flag dropped without a zero write");

   AST_READ_IDLE_ZERO: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      CLK_EN_I && !RD_I |=> RDATA_O == 8'h00)
      else $error("read data not zero outside a read");

   AST_TIMER_FLAG_SET: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      CLK_EN_I && cd_event |=> cd_flag_q)
      else $error("timer event did not set the flag");

   AST_TIMER_RELEASE: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      CLK_EN_I && timer_irq_q && release_done && !cd_event |=> !timer_irq_q)
      else $error("timer interrupt not released on time");

   AST_RELEASE_LEN: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      CLK_EN_I && cd_event && countdown_irq_enable && !wr_ctrl
      |=> timer_irq_q && release_q == $past(release_len))
      else $error("release count loaded wrong");

   AST_SOURCE_SELECT: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
      source_select == rtc_irq_pkg::SRC_1HZ && !countdown_stop && !clock_stop
      |-> src_tick == TICK_1HZ_I)
      else $error("wrong countdown source");

endmodule : rtc_irq_top
`default_nettype wire

// [sim/host_model.sv]
// Purpose: host side of the block: register master and interrupt pin
// Assumes: strobes change by nba right after a rising edge
// Notes:   the pin has a pull-up, so it reads high unless pulled low
`timescale 1ns/100ps
`default_nettype none
module host_model (
   // clock
   input  wire logic       clk_i,
   // register port
   output var  logic [3:0] addr_o,
   output var  logic [7:0] wdata_o,
   output var  logic       wr_o,
   output var  logic       rd_o,
   input  wire logic [7:0] rdata_i,
   // open-drain pin
   input  wire logic       irq_o_i,
   input  wire logic       irq_oe_i,
   output logic            irq_n_o
);
   assign irq_n_o = irq_oe_i ? irq_o_i : 1'b1;
   initial begin
      addr_o  = 4'h0;
      wdata_o = 8'h00;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr_o  <= a;
      wdata_o <= v;
      wr_o    <= 1'b1;
      @(posedge clk_i);
      wr_o    <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge clk_i);
      rd_o   <= 1'b0;
      @(negedge clk_i);
      v = rdata_i;
   endtask : rd
endmodule : host_model
`default_nettype wire

// [sim/tb_top.sv]
// Purpose: self-checking bench for the timer and alarm interrupt block
// Assumes: host_model drives the register port and resolves the pin
// Notes:   slow release shortened to REL cycles
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   localparam int REL = 20;
   logic       clk;
   logic       rst;
   logic       ce;
   logic [4:0] ticks;
   logic [6:0] minute;
   logic [5:0] hour;
   logic [5:0] date;
   logic [2:0] wday;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       irq_o;
   logic       irq_oe;
   logic       irq_n;
   logic [7:0] d;
   logic [7:0] p;
   logic [31:0] r;
   int         n_errors;
   int         checks_done;
   initial clk = 1'b0;
   always #25 clk = ~clk;
   rtc_irq_top #(.PRESET_W(16), .RELEASE_SLOW(REL)) dut (
      .MCLK_I(clk), .SYS_RST_I(rst), .CLK_EN_I(ce),
      .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
      .TICK_4096HZ_I(ticks[0]), .TICK_64HZ_I(ticks[1]), .TICK_1HZ_I(ticks[2]),
      .TICK_MINUTE_I(ticks[3]), .TICK_HOUR_I(ticks[4]),
      .MINUTE_I(minute), .HOUR_I(hour), .DATE_I(date), .WEEKDAY_I(wday),
      .IRQ_I(irq_n), .IRQ_O(irq_o), .IRQ_OE_O(irq_oe));
   host_model host (
      .clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
      .rdata_i(rdata), .irq_o_i(irq_o), .irq_oe_i(irq_oe), .irq_n_o(irq_n));
   task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : chk8
   task automatic pin(input logic e);
      @(negedge clk);
      checks_done++;
      if (irq_n !== e) begin
         n_errors++;
         $display("Error irq pin expected %b seen %b", e, irq_n);
      end
   endtask : pin
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic flags(input logic [7:0] e);
      cyc(3);
      host.rd(rtc_irq_pkg::FLAGS_ADDR, d);
      chk8("flags", e, d);
   endtask : flags
   task automatic tick(input logic [4:0] v);
      @(posedge clk);
      ticks <= v;
      @(posedge clk);
      ticks <= 5'h00;
   endtask : tick
   // other sources pulse first and must not move the count
   task automatic count(input int s, input int n);
      repeat (n) begin
         tick(~(5'h01 << s));
         tick(5'h01 << s);
      end
   endtask : count
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   function automatic logic hit(input logic [7:0] ma, ha, wa, input logic ds);
      logic w;
      w = ds ? (wa[5:0] == date) : wa[wday];
      return (ma[7] | ma[6:0] == minute) & (ha[7] | ha[5:0] == hour) & (wa[7] | w);
   endfunction : hit
   task automatic alarm(input logic [7:0] ma, ha, wa, input logic ds, input logic keep);
      logic e;
      host.wr(rtc_irq_pkg::IRQ_CTRL_ADDR, 8'h00);
      // weekday may have been set by nba in the calling time step
      e = hit(ma, ha, wa, ds);
      host.wr(rtc_irq_pkg::MIN_ALARM_ADDR, ma);
      host.wr(rtc_irq_pkg::HOUR_ALARM_ADDR, ha);
      host.wr(rtc_irq_pkg::WDAY_ALARM_ADDR, wa);
      host.wr(rtc_irq_pkg::EXT_CFG_ADDR, {4'h0, ds, 3'h0});
      host.wr(rtc_irq_pkg::IRQ_CTRL_ADDR, 8'h08);
      flags(8'h00);
      tick(5'h08);
      flags({4'h0, e, 3'h0});
      pin(~e);
      if (!keep)
         host.wr(rtc_irq_pkg::FLAGS_ADDR, 8'h00);
   endtask : alarm
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      ticks = 5'h00;
      minute = 7'h34;
      hour = 6'h12;
      date = 6'h15;
      wday = 3'h3;
      n_errors = 0;
      checks_done = 0;
      void'($urandom(45076));
      cyc(2);
      rst <= 1'b0;
      for (int a = 0; a < 16; a++) begin
         host.rd(4'(a), d);
         chk8("reset value", 8'h00, d);
      end
      host.wr(rtc_irq_pkg::IRQ_CTRL_ADDR, 8'hff);
      host.rd(rtc_irq_pkg::IRQ_CTRL_ADDR, d);
      chk8("control", rtc_irq_pkg::IRQ_CTRL_MASK, d);
      $display("registers done");
      for (int s = 0; s < 5; s++) begin
         p = 8'($urandom_range(2, 5));
         host.wr(rtc_irq_pkg::EXT_CFG_ADDR, {5'h00, 3'(s)});
         host.wr(rtc_irq_pkg::PRESET_LO_ADDR, p);
         host.wr(rtc_irq_pkg::PRESET_HI_ADDR, 8'h00);
         host.wr(rtc_irq_pkg::IRQ_CTRL_ADDR, 8'h10);
         host.wr(rtc_irq_pkg::EXT_CFG_ADDR, {5'h02, 3'(s)});
         count(s, p - 1);
         flags(8'h00);
         count(s, 1);
         flags(8'h10);
         pin(1'b0);
         cyc((s == 0 ? rtc_irq_pkg::RELEASE_FAST_CYC : REL) - 8);
         pin(1'b0);
         cyc(12);
         pin(1'b1);
         host.wr(rtc_irq_pkg::FLAGS_ADDR, 8'h00);
         count(s, p);
         flags(8'h10);
         host.wr(rtc_irq_pkg::FLAGS_ADDR, 8'h00);
         count(s, 1);
         host.wr(rtc_irq_pkg::EXT_CFG_ADDR, {5'h00, 3'(s)});
         host.wr(rtc_irq_pkg::EXT_CFG_ADDR, {5'h02, 3'(s)});
         count(s, p - 1);
         flags(8'h00);
         count(s, 1);
         flags(8'h10);
         host.wr(rtc_irq_pkg::IRQ_CTRL_ADDR, 8'h00);
         host.wr(rtc_irq_pkg::EXT_CFG_ADDR, 8'h00);
         host.wr(rtc_irq_pkg::FLAGS_ADDR, 8'h00);
      end
      $display("countdown done");
      for (int a = 8; a < 11; a++) begin
         p = 8'($urandom);
         host.wr(4'(a), p);
         host.rd(4'(a), d);
         chk8("alarm storage", p, d);
      end
      alarm(8'h34, 8'h80, 8'h80, 1'b0, 1'b0);
      alarm(8'h35, 8'h80, 8'h80, 1'b0, 1'b0);
      alarm(8'h80, 8'h12, 8'h0a, 1'b0, 1'b0);
      alarm(8'h80, 8'h12, 8'h15, 1'b1, 1'b0);
      alarm(8'h80, 8'h80, 8'h15, 1'b0, 1'b0);
      repeat (8) begin
         r = $urandom;
         wday <= 3'($urandom_range(0, 6));
         alarm({r[0], minute ^ {6'h00, r[1]}}, {r[2], 1'b0, hour}, {r[3], r[14:8]}, r[4], 1'b0);
      end
      alarm(8'h80, 8'h80, 8'h80, 1'b0, 1'b1);
      cyc(200);
      pin(1'b0);
      host.wr(rtc_irq_pkg::FLAGS_ADDR, 8'hff);
      flags(8'h08);
      host.wr(rtc_irq_pkg::IRQ_CTRL_ADDR, 8'h00);
      pin(1'b1);
      flags(8'h08);
      host.wr(rtc_irq_pkg::FLAGS_ADDR, 8'h00);
      flags(8'h00);
      host.wr(rtc_irq_pkg::IRQ_CTRL_ADDR, 8'h0a);
      tick(5'h08);
      flags(8'h00);
      pin(1'b1);
      host.wr(rtc_irq_pkg::IRQ_CTRL_ADDR, 8'h08);
      @(posedge clk);
      ce <= 1'b0;
      tick(5'h08);
      @(posedge clk);
      ce <= 1'b1;
      flags(8'h00);
      tick(5'h08);
      flags(8'h08);
      pin(1'b0);
      $display("alarm done");
      give_verdict();
   end
   initial begin
      cyc(40000);
      n_errors++;
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
